// >>> pin_mode_device.sv
// device end: bus clock, port a bit 2/3 pin function and boot mode, debug bit engine
// Functional notes
// - bus clock is half the clock source
// - fixed clock synchronized, at most half bus
// - bit 2 pin is input after power-on
// - reset-pin-enable turns bit 2 into reset
// - reset function sticks until power-on reset
// - low level on reset pin resets device
// - reset pin gets pullup automatically
// - bit 3 is mode select in reset, then debug
// - pullup on bit 3 in debug/mode role
// - bit 3 output-only after debug-pin-enable cleared
// - high mode select gives run mode
// - low mode select gives background mode
// - each debug bit lasts 16 debug clocks
// - debug controller runs at bus clock
// - pseudo open-drain with driven speedup pulse
// - other shared pins are plain inputs
// - highest-priority pin function wins
`timescale 1ns/1ps
module pin_mode_device
  import pin_mode_pkg::*;
#(
  parameter int BITS = pin_mode_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic                 ref_clk_in,
  input  wire logic                 reset_in,
  input  wire logic                 por_in,
  // system options register bits and port data
  input  wire logic                 reset_pin_enable_in,
  input  wire logic                 debug_pin_enable_in,
  input  wire logic                 port_a_bit3_data_in,
  // debug transmit request
  input  wire logic                 tx_valid_in,
  input  wire logic                 tx_bit_in,
  // pins
  pin_link_if.device                link,
  // status
  output logic                      bus_clk_en_out,
  output logic                      fix_clk_en_out,
  output logic                      system_reset_out,
  output pin_mode_pkg::boot_mode_t  boot_mode_out,
  output logic                      port_a_bit2_in_out,
  output logic                      other_pins_pull_out,
  output logic                      tx_ready_out,
  output logic                      rx_valid_out,
  output logic                      rx_bit_out
);
  import pin_mode_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic a2_meta, a2_sync, a3_meta, a3_sync, a3_prev;
  logic next_a2_meta, next_a2_sync, next_a3_meta, next_a3_sync, next_a3_prev;

  always_comb begin
    next_a2_meta = link.a2_level;
    next_a2_sync = a2_meta;
    next_a3_meta = link.a3_level;
    next_a3_sync = a3_meta;
    next_a3_prev = a3_sync;
  end

  // no reset: the mode select level must reach the boot latch while power-on reset is high
  always_ff @(posedge ref_clk_in) begin
    a2_meta <= next_a2_meta;
    a2_sync <= next_a2_sync;
    a3_meta <= next_a3_meta;
    a3_sync <= next_a3_sync;
    a3_prev <= next_a3_prev;
  end

  // ----------------------------------------
  // bus and fixed clock enables
  // ----------------------------------------
  // bus clock is a one-in-two enable so everything stays on ref_clk_in
  logic       bus_phase, next_bus_phase;
  logic [2:0] fix_cnt, next_fix_cnt;

  always_comb begin
    next_bus_phase = ~bus_phase;
    next_fix_cnt   = fix_cnt;
    if (bus_phase) begin
      next_fix_cnt = (fix_cnt == 3'(FIX_DIV - 1)) ? 3'h0 : fix_cnt + 3'h1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      bus_phase <= 1'b0;
      fix_cnt   <= 3'h0;
    end else begin
      bus_phase <= next_bus_phase;
      fix_cnt   <= next_fix_cnt;
    end
  end

  assign bus_clk_en_out = bus_phase;
  // fixed clock is generated from the bus enable, so it is synchronous by design
  assign fix_clk_en_out = bus_phase && (fix_cnt == 3'(FIX_DIV - 1));

  // ----------------------------------------
  // reset pin function
  // ----------------------------------------
  logic rst_pin_mode, next_rst_pin_mode;

  always_comb begin
    next_rst_pin_mode = rst_pin_mode | reset_pin_enable_in;
  end

  // only power-on reset clears it, a pin reset must not undo itself
  always_ff @(posedge ref_clk_in) begin
    if (por_in) begin
      rst_pin_mode <= RESET_PIN_ENABLE_RST;
    end else begin
      rst_pin_mode <= next_rst_pin_mode;
    end
  end

  assign system_reset_out    = reset_in | por_in | (rst_pin_mode & ~a2_sync);
  assign link.a2_dev_pullup  = rst_pin_mode;
  assign port_a_bit2_in_out  = rst_pin_mode ? 1'b0 : a2_sync;
  assign other_pins_pull_out = 1'b0;

  // ----------------------------------------
  // boot mode and bit 3 function
  // ----------------------------------------
  boot_mode_t mode, next_mode;
  logic       in_reset_d, next_in_reset_d;

  always_comb begin
    next_in_reset_d = system_reset_out;
    next_mode       = mode;
    if (in_reset_d && !system_reset_out) begin
      next_mode = a3_sync ? RUN_MODE : BACKGROUND_MODE;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (por_in) begin
      mode       <= RUN_MODE;
      in_reset_d <= 1'b1;
    end else begin
      mode       <= next_mode;
      in_reset_d <= next_in_reset_d;
    end
  end

  assign boot_mode_out = mode;

  logic debug_role;
  // debug/mode select outranks the output-only port function
  assign debug_role         = system_reset_out | debug_pin_enable_in;
  assign link.a3_dev_pullup = debug_role;

  // ----------------------------------------
  // debug bit engine, ticks on bus clock
  // ----------------------------------------
  typedef enum {IDLE, TX_LOW, TX_SPEED, TX_REST, RX_WAIT, RX_REST} bit_state_t;
  bit_state_t st, next_st;
  logic [4:0] cnt, next_cnt;
  logic       bitv, next_bitv;
  logic       rxv, next_rxv;
  logic       rxb, next_rxb;
  logic       active;

  assign active = debug_role && !system_reset_out;

  always_comb begin
    next_st   = st;
    next_cnt  = cnt;
    next_bitv = bitv;
    next_rxv  = 1'b0;
    next_rxb  = rxb;
    if (!active) begin
      next_st = IDLE;
    end else if (st == IDLE) begin
      // taken on a bus tick only, so every sent bit spans whole bus cycles
      if (bus_phase && tx_valid_in) begin
        next_st   = TX_LOW;
        next_cnt  = 5'h0;
        next_bitv = tx_bit_in;
      end else if (a3_prev && !a3_sync) begin
        // the edge stands one clock, so it is looked for on every clock
        next_st  = RX_WAIT;
        next_cnt = 5'h1;
      end
    end else if (bus_phase) begin
      next_cnt = cnt + 5'h1;
      case (st)
        TX_LOW: begin
          if (cnt == 5'(bitv ? LOW_ONE_CYCLES - 1 : LOW_ZERO_CYCLES - 1)) begin
            next_st = TX_SPEED;
          end
        end
        TX_SPEED: begin
          if (cnt == 5'(bitv ? LOW_ONE_CYCLES + SPEEDUP_CYCLES - 1 : LOW_ZERO_CYCLES + SPEEDUP_CYCLES - 1)) begin
            next_st = TX_REST;
          end
        end
        TX_REST: begin
          if (cnt == 5'(BITS - 1)) begin
            next_st = IDLE;
          end
        end
        RX_WAIT: begin
          if (cnt == 5'(SAMPLE_CYCLE)) begin
            next_st  = RX_REST;
            next_rxv = 1'b1;
            next_rxb = a3_sync;
          end
        end
        RX_REST: begin
          if (cnt == 5'(BITS - 1)) begin
            next_st = IDLE;
          end
        end
        default: next_st = IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in || por_in) begin
      st   <= IDLE;
      cnt  <= 5'h0;
      bitv <= 1'b0;
      rxv  <= 1'b0;
      rxb  <= 1'b0;
    end else begin
      st   <= next_st;
      cnt  <= next_cnt;
      bitv <= next_bitv;
      rxv  <= next_rxv;
      rxb  <= next_rxb;
    end
  end

  assign tx_ready_out = active && (st == IDLE) && bus_phase;
  assign rx_valid_out = rxv;
  assign rx_bit_out   = rxb;

  // low is driven, then a short driven-high speedup, then the pullup holds it
  always_comb begin
    link.a3_dev_out = 1'b0;
    link.a3_dev_oe  = 1'b0;
    if (debug_role) begin
      link.a3_dev_oe  = (st == TX_LOW) || (st == TX_SPEED);
      link.a3_dev_out = (st == TX_SPEED);
    end else begin
      link.a3_dev_oe  = 1'b1;
      link.a3_dev_out = port_a_bit3_data_in;
    end
  end
endmodule

// >>> pin_mode_pkg.sv
// shared constants for the reset/debug pin mode select ends
package pin_mode_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int BIT_CYCLES      = 16;
  localparam int SPEEDUP_CYCLES  = 1;
  localparam int SAMPLE_CYCLE    = 8;
  localparam int LOW_ONE_CYCLES  = 4;
  localparam int LOW_ZERO_CYCLES = 13;
  localparam int FIX_DIV         = 4;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic RESET_PIN_ENABLE_RST = 1'b0;
  localparam logic DEBUG_PIN_ENABLE_RST = 1'b1;

  typedef enum logic {RUN_MODE, BACKGROUND_MODE} boot_mode_t;
endpackage

// >>> pin_link_if.sv
// pins between the device and the debug host / external reset source
`timescale 1ns/1ps
interface pin_link_if;
  logic a2_host_out;
  logic a2_host_oe;
  logic a2_dev_pullup;
  logic a3_dev_out;
  logic a3_dev_oe;
  logic a3_dev_pullup;
  logic a3_host_out;
  logic a3_host_oe;
  logic a2_level;
  logic a3_level;

  modport device (
    input  a2_level,
    input  a3_level,
    output a2_dev_pullup,
    output a3_dev_out,
    output a3_dev_oe,
    output a3_dev_pullup
  );
  modport host (
    input  a2_level,
    input  a3_level,
    output a2_host_out,
    output a2_host_oe,
    output a3_host_out,
    output a3_host_oe
  );
endinterface

// >>> pin_mode_host.sv
// host end: external reset source and debug pod
`timescale 1ns/1ps
module pin_mode_host
  import pin_mode_pkg::*;
#(
  parameter int BITS = pin_mode_pkg::BIT_CYCLES
) (
  // clock and reset
  input  wire logic ref_clk_in,
  input  wire logic reset_in,
  // user controls
  input  wire logic ext_reset_in,
  input  wire logic force_bgnd_in,
  input  wire logic tx_valid_in,
  input  wire logic tx_bit_in,
  // pins
  pin_link_if.host  link,
  // status
  output logic      tx_ready_out
);
  import pin_mode_pkg::*;

  // ----------------------------------------
  // bit timer, counted in target bus cycles
  // ----------------------------------------
  logic       phase, next_phase;
  logic       busy, next_busy;
  logic       bitv, next_bitv;
  logic [4:0] cnt, next_cnt;

  always_comb begin
    next_phase = ~phase;
    next_busy  = busy;
    next_bitv  = bitv;
    next_cnt   = cnt;
    // start on a tick of the own divider so the low phase is whole bus cycles
    if (!busy && tx_valid_in && phase) begin
      next_busy = 1'b1;
      next_bitv = tx_bit_in;
      next_cnt  = 5'h0;
    end else if (busy && phase) begin
      next_cnt = cnt + 5'h1;
      if (cnt == 5'(BITS - 1)) begin
        next_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      phase <= 1'b0;
      busy  <= 1'b0;
      bitv  <= 1'b0;
      cnt   <= 5'h0;
    end else begin
      phase <= next_phase;
      busy  <= next_busy;
      bitv  <= next_bitv;
      cnt   <= next_cnt;
    end
  end

  assign tx_ready_out = !busy && !force_bgnd_in && phase;

  logic [4:0] low_end;
  assign low_end = 5'(bitv ? LOW_ONE_CYCLES : LOW_ZERO_CYCLES);

  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  always_comb begin
    link.a2_host_oe  = ext_reset_in;
    link.a2_host_out = 1'b0;
    link.a3_host_oe  = 1'b0;
    link.a3_host_out = 1'b0;
    if (force_bgnd_in) begin
      link.a3_host_oe = 1'b1;
    end else if (busy && cnt < low_end) begin
      link.a3_host_oe = 1'b1;
    end else if (busy && cnt < low_end + 5'(SPEEDUP_CYCLES)) begin
      link.a3_host_oe  = 1'b1;
      link.a3_host_out = 1'b1;
    end
  end
endmodule

// >>> pin_link_assertions.sv
// checker on the pin link between device and host ends
`timescale 1ns/1ps
module pin_link_assertions
  import pin_mode_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic por_in,
  // link
  input wire logic a2_dev_pullup,
  input wire logic a3_dev_out,
  input wire logic a3_dev_oe,
  input wire logic a3_dev_pullup,
  input wire logic a3_host_out,
  input wire logic a3_host_oe
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in || por_in);
  logic       dlo;
  logic       dhi;
  logic       hlo;
  logic       hhi;
  logic [5:0] dcnt;
  logic [5:0] hcnt;
  logic [5:0] gap;
  assign dlo = a3_dev_pullup && a3_dev_oe && !a3_dev_out;
  assign dhi = a3_dev_pullup && a3_dev_oe && a3_dev_out;
  assign hlo = a3_host_oe && !a3_host_out;
  assign hhi = a3_host_oe && a3_host_out;
  // counters saturate so a long forced low never wraps onto a legal width
  always_ff @(posedge ref_clk_in) begin
    if (reset_in || por_in) begin
      dcnt <= '0;
      hcnt <= '0;
      gap  <= 6'h3f;
    end else begin
      dcnt <= !dlo ? '0 : (dcnt == 6'h3f ? dcnt : dcnt + 6'h1);
      hcnt <= !hlo ? '0 : (hcnt == 6'h3f ? hcnt : hcnt + 6'h1);
      gap  <= (dlo && $rose(dlo)) ? '0 : (gap == 6'h3f ? gap : gap + 6'h1);
    end
  end
  sequence dev_edge;
    dlo ##1 dhi;
  endsequence
  sequence host_edge;
    hlo ##1 hhi;
  endsequence
  a_dev_low_width: assert property (dev_edge |-> dcnt == 2*LOW_ONE_CYCLES || dcnt == 2*LOW_ZERO_CYCLES)
    else $error("device low phase width wrong");
  a_host_low_width: assert property (host_edge |-> hcnt == 2*LOW_ONE_CYCLES || hcnt == 2*LOW_ZERO_CYCLES)
    else $error("host low phase width wrong");
  a_dev_speedup: assert property (dev_edge |=> dhi ##1 !a3_dev_oe)
    else $error("device speedup pulse wrong");
  a_host_speedup: assert property (host_edge |=> hhi ##1 !a3_host_oe)
    else $error("host speedup pulse wrong");
  a_dev_release: assert property (dev_edge ##2 !a3_dev_oe |=> !a3_dev_oe[*3])
    else $error("device drives after release");
  a_bit_spacing: assert property ($rose(dlo) |-> gap >= 6'd31)
    else $error("device bits closer than one bit time");
  a_reset_pin_sticky: assert property (disable iff (por_in) a2_dev_pullup |=> a2_dev_pullup)
    else $error("reset pin mode lost");
  a_port_driven: assert property (!a3_dev_pullup |-> a3_dev_oe)
    else $error("output port not driven");
endmodule

// >>> reset_debug_pin_mode_select_test.sv
// self-checking bench for the device and host ends of the pin link
`timescale 1ns/1ps
`define CHK(s, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s expected %0h seen %0h", s, e, g); end end
`define WT(s) begin k = 0; @(negedge clk); while ((s) !== 1'b1 && k < 99) begin @(negedge clk); k++; end \
  if (k == 99) begin err_count++; print_verdict(); end end
module reset_debug_pin_mode_select_test;
  import pin_mode_pkg::*;
  logic clk = 0, por = 1, rst = 1, rpe = 0, dpe = 1, pdat = 0, dv = 0, db = 0;
  logic xr = 0, fb = 0, hv = 0, hb = 0, flt = 0;
  logic bus_en, fix_en, sys_rst, b2, opull, drdy, rxv, rxb, hrdy, eb;
  boot_mode_t boot;
  int err_count = 0, cmp_count = 0, i, k, n, m;
  logic q[$];
  pin_link_if lk ();
  // undriven lines without pullup toggle so a stale value never passes
  assign lk.a2_level = lk.a2_host_oe ? lk.a2_host_out : (lk.a2_dev_pullup | flt);
  assign lk.a3_level = ((lk.a3_dev_oe & ~lk.a3_dev_out) | (lk.a3_host_oe & ~lk.a3_host_out)) ? 1'b0
                     : (lk.a3_dev_oe | lk.a3_host_oe | lk.a3_dev_pullup | flt);
  pin_mode_device i_pin_mode_device (.ref_clk_in(clk), .reset_in(rst), .por_in(por),
    .reset_pin_enable_in(rpe), .debug_pin_enable_in(dpe), .port_a_bit3_data_in(pdat),
    .tx_valid_in(dv), .tx_bit_in(db), .link(lk), .bus_clk_en_out(bus_en), .fix_clk_en_out(fix_en),
    .system_reset_out(sys_rst), .boot_mode_out(boot), .port_a_bit2_in_out(b2),
    .other_pins_pull_out(opull), .tx_ready_out(drdy), .rx_valid_out(rxv), .rx_bit_out(rxb));
  pin_mode_host i_pin_mode_host (.ref_clk_in(clk), .reset_in(rst), .ext_reset_in(xr),
    .force_bgnd_in(fb), .tx_valid_in(hv), .tx_bit_in(hb), .link(lk), .tx_ready_out(hrdy));
  pin_link_assertions i_pin_link_assertions (.ref_clk_in(clk), .reset_in(rst), .por_in(por),
    .a2_dev_pullup(lk.a2_dev_pullup), .a3_dev_out(lk.a3_dev_out), .a3_dev_oe(lk.a3_dev_oe),
    .a3_dev_pullup(lk.a3_dev_pullup), .a3_host_out(lk.a3_host_out), .a3_host_oe(lk.a3_host_oe));
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) flt <= ~flt;
  task cyc(input int c);
    repeat (c) @(posedge clk);
  endtask
  task print_verdict;
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task bootup(input logic f);
    fb <= f;
    por <= 1;
    rst <= 1;
    cyc(12);
    por <= 0;
    rst <= 0;
    cyc(3);
    fb <= 0;
    cyc(4);
    `CHK("boot mode", f ? BACKGROUND_MODE : RUN_MODE, boot)
  endtask
  // requests stand from a rising edge until the edge at which ready is seen high
  task hsend(input logic b);
    cyc(1);
    hv <= 1;
    hb <= b;
    q.push_back(b);
    `WT(hrdy)
    cyc(1);
    hv <= 0;
    `WT(rxv)
    eb = q.pop_front();
    `CHK("rx bit", eb, rxb)
  endtask
  task dsend(input logic b);
    cyc(1);
    dv <= 1;
    db <= b;
    `WT(drdy)
    cyc(1);
    dv <= 0;
    m = 0;
    @(negedge clk);
    while (lk.a3_level !== 1'b0 && m < 9) begin
      @(negedge clk);
      m++;
    end
    n = 0;
    while (lk.a3_level === 1'b0 && n < 40) begin
      @(negedge clk);
      n++;
    end
    `CHK("low cycles", b ? 2*LOW_ONE_CYCLES : 2*LOW_ZERO_CYCLES, n)
    `WT(drdy)
  endtask
  initial begin
    void'($urandom(32'hfe7b_7f43));
    bootup(0);
    `CHK("other pulls", 1'b0, opull)
    `CHK("bit2 pullup", 1'b0, lk.a2_dev_pullup)
    `CHK("bit3 pullup", 1'b1, lk.a3_dev_pullup)
    n = 0;
    m = 0;
    repeat (64) begin
      @(negedge clk);
      n += int'(bus_en);
      m += int'(fix_en);
    end
    `CHK("bus ticks", 32, n)
    `CHK("fixed ticks", 32/FIX_DIV, m)
    for (i = 0; i < 8; i++) begin
      hsend(i < 2 ? i[0] : 1'($urandom));
      dsend(i < 2 ? i[0] : 1'($urandom));
    end
    cyc(1);
    xr <= 1;
    cyc(4);
    `CHK("bit2 input", 1'b0, b2)
    `CHK("system reset", 1'b0, sys_rst)
    xr <= 0;
    rpe <= 1;
    cyc(2);
    rpe <= 0;
    cyc(2);
    `CHK("bit2 pullup", 1'b1, lk.a2_dev_pullup)
    `CHK("bit2 input", 1'b0, b2)
    xr <= 1;
    cyc(4);
    `CHK("system reset", 1'b1, sys_rst)
    xr <= 0;
    cyc(4);
    `CHK("system reset", 1'b0, sys_rst)
    rst <= 1;
    cyc(2);
    rst <= 0;
    cyc(4);
    `CHK("bit2 pullup", 1'b1, lk.a2_dev_pullup)
    bootup(1);
    `CHK("bit2 pullup", 1'b0, lk.a2_dev_pullup)
    rst <= 1;
    cyc(2);
    rst <= 0;
    cyc(4);
    `CHK("boot mode", RUN_MODE, boot)
    dpe <= 0;
    for (i = 0; i < 2; i++) begin
      pdat <= i[0];
      cyc(4);
      `CHK("bit3 level", i[0], lk.a3_level)
    end
    `CHK("bit3 pullup", 1'b0, lk.a3_dev_pullup)
    dpe <= 1;
    cyc(4);
    print_verdict();
  end
endmodule
